// *** shared/udec_pkg.sv ***
// Package of constants and types for the transmit driver-enable controller.
// Notes on behaviour
// - Without flow control, data write asserts enable.
// - Enable held across back-to-back characters.
// - Start edge one bit after enable.
// - Enable drops 1-2 clocks after stop.
// - CTS fall to enable: 3 clocks minimum.
// - Enable output polarity is selectable.
// - Flow control holds character until CTS low.
package udec_pkg;
    localparam int          DATA_W       = 8;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          DIV_W        = 16;
    localparam int          CLK_HZ       = 25000000;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          BITS_PER_CHAR = 10;
    localparam logic [3:0]  BIT_LAST     = 4'(BITS_PER_CHAR - 1);
    localparam logic [15:0] DIV_RESET    = 16'h00D9;
    localparam logic [1:0]  SYNC_RESET   = 2'h3;
    typedef enum logic [2:0] {
        UDEC_IDLE,
        UDEC_LEAD,
        UDEC_SHIFT,
        UDEC_TAIL
    } udec_state_e;
endpackage : udec_pkg

// *** design/udec_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module udec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic             i_wvalid,
    output      logic             o_wready,
    output      logic [WIDTH-1:0] o_rdata,
    output      logic             o_rvalid,
    input  wire logic             i_rready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    wire              push = i_wvalid && o_wready;
    wire              pop  = o_rvalid && i_rready;
    assign o_wready = (count != (AW+1)'(DEPTH));
    assign o_rvalid = (count != '0);
    assign o_rdata  = mem[rptr];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (push) wptr <= wptr + 1'b1;
            if (pop) rptr <= rptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge i_clk) begin
        if (push) mem[wptr] <= i_wdata;
    end
endmodule : udec_fifo

// *** design/udec_ctrl.sv ***
// Transmit path with line driver enable sequencing and flow control.
`timescale 1ns/1ps
module udec_ctrl
    import udec_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic [DATA_W-1:0] i_tx_data,
    input  wire logic              i_tx_write,
    output      logic              o_tx_ready,
    input  wire logic [DIV_W-1:0]  i_bit_div,
    input  wire logic              i_flow_en,
    input  wire logic              i_de_active_low,
    input  wire logic              i_cts_n,
    output      logic              o_txd,
    output      logic              o_line_driver_enable,
    output      logic              o_busy
);
    logic [1:0]        rst_sync;
    logic              rst_n;
    logic [1:0]        cts_sync;
    udec_state_e       state;
    logic [DIV_W-1:0]  bit_cnt;
    logic [3:0]        bit_idx;
    logic [9:0]        shreg;
    logic              de;
    logic              txd;
    logic              cts_gate;
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;
    wire               fifo_pop;
    wire               bit_end   = (bit_cnt == i_bit_div);
    wire               cts_low   = !cts_sync[1];
    wire               may_start = fifo_valid && (!i_flow_en || cts_gate);

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) cts_sync <= SYNC_RESET;
        else cts_sync <= {cts_sync[0], i_cts_n};
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) cts_gate <= 1'b0;
        else cts_gate <= cts_low;
    end

    udec_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk    (i_clk),
        .i_rst_n  (rst_n),
        .i_wdata  (i_tx_data),
        .i_wvalid (i_tx_write),
        .o_wready (o_tx_ready),
        .o_rdata  (fifo_data),
        .o_rvalid (fifo_valid),
        .i_rready (fifo_pop)
    );

    assign fifo_pop = (state == UDEC_IDLE || (state == UDEC_SHIFT && bit_end &&
                       bit_idx == BIT_LAST)) && may_start;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= UDEC_IDLE;
            bit_cnt <= '0;
            bit_idx <= '0;
            shreg   <= 10'h3FF;
            de      <= 1'b0;
            txd     <= 1'b1;
        end else begin
            unique case (state)
                UDEC_IDLE: begin
                    txd     <= 1'b1;
                    bit_cnt <= '0;
                    if (may_start) begin
                        de    <= 1'b1;
                        shreg <= {1'b1, fifo_data, 1'b0};
                        state <= UDEC_LEAD;
                    end
                end
                UDEC_LEAD: begin
                    bit_cnt <= bit_end ? '0 : bit_cnt + 1'b1;
                    if (bit_end) begin
                        txd     <= shreg[0];
                        shreg   <= {1'b1, shreg[9:1]};
                        bit_idx <= '0;
                        state   <= UDEC_SHIFT;
                    end
                end
                UDEC_SHIFT: begin
                    bit_cnt <= bit_end ? '0 : bit_cnt + 1'b1;
                    if (bit_end) begin
                        if (bit_idx != BIT_LAST) begin
                            txd     <= shreg[0];
                            shreg   <= {1'b1, shreg[9:1]};
                            bit_idx <= bit_idx + 1'b1;
                        end else if (may_start) begin
                            txd     <= 1'b0;
                            shreg   <= {1'b1, 1'b1, fifo_data};
                            bit_idx <= '0;
                        end else begin
                            txd   <= 1'b1;
                            state <= UDEC_TAIL;
                        end
                    end
                end
                UDEC_TAIL: begin
                    de    <= 1'b0;
                    state <= UDEC_IDLE;
                end
                default: state <= UDEC_IDLE;
            endcase
        end
    end

    assign o_txd = txd;
    assign o_line_driver_enable = de ^ i_de_active_low;
    assign o_busy = (state != UDEC_IDLE);
endmodule : udec_ctrl

// *** verification/udec_ctrl_checker.sv ***
// Checker for the driver enable timing.
`timescale 1ns/1ps
module udec_ctrl_checker import udec_pkg::*; (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_tx_write,
    input wire logic o_tx_ready,
    input wire logic [DIV_W-1:0] i_bit_div,
    input wire logic i_flow_en,
    input wire logic i_de_active_low,
    input wire logic i_cts_n,
    input wire logic o_txd,
    input wire logic o_line_driver_enable,
    input wire logic o_busy
);
    wire de = o_line_driver_enable ^ i_de_active_low;
    int lead;
    always_ff @(posedge i_clk) lead <= $rose(de) ? 1 : (lead != 0 && o_txd) ? lead + 1 : 0;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_load;
        !i_flow_en && !o_busy && i_tx_write && o_tx_ready;
    endsequence
    a_write_enable: assert property (s_load |-> ##[1:3] de)
        else $error("enable late");
    a_start_lead: assert property ($fell(o_txd) && lead != 0 |->
        lead >= i_bit_div + 1 && lead <= i_bit_div + 2) else $error("lead wrong");
    a_fall_enabled: assert property ($fell(o_txd) |-> de)
        else $error("start without enable");
    a_drop_line: assert property ($fell(de) |-> $past(o_txd) && $past(o_txd, 2))
        else $error("early drop");
    a_idle_line: assert property (!de |-> o_txd)
        else $error("line not idle");
    a_idle_pol: assert property (!o_busy |-> o_line_driver_enable == i_de_active_low)
        else $error("idle level");
    a_busy_enable: assert property (de |-> o_busy)
        else $error("enable when idle");
    a_cts_gate: assert property ($rose(de) && i_flow_en |->
        !$past(i_cts_n) && !$past(i_cts_n, 2)) else $error("cts gate");
endmodule : udec_ctrl_checker

// *** verification/udec_cts_partner.sv ***
// Model of the remote flow-control source.
`timescale 1ns/1ps
module udec_cts_partner (
    input  wire logic i_clk,
    input  wire logic i_grant,
    output logic      o_cts_n = 1'b1
);
    always @(posedge i_clk) o_cts_n <= !i_grant;
endmodule : udec_cts_partner

// *** verification/udec_ctrl_tb.sv ***
// Testbench for the driver enable controller.
`timescale 1ns/1ps
module udec_ctrl_tb import udec_pkg::*;;
    logic clk = 0, nrst = 0, wr = 0, flow = 0, pol = 0, grant = 0;
    logic [7:0] data = 0, a, b, c;
    int w;
    logic [15:0] div = 16'h0003;
    wire rdy, txd, de_pin, busy, cts_n;
    int n_errors = 0, n_checks = 0, seed = 29, cyc = 0;
    udec_ctrl i_udec_ctrl (.i_clk(clk), .i_nrst(nrst), .i_tx_data(data), .i_tx_write(wr),
        .o_tx_ready(rdy), .i_bit_div(div), .i_flow_en(flow), .i_de_active_low(pol),
        .i_cts_n(cts_n), .o_txd(txd), .o_line_driver_enable(de_pin), .o_busy(busy));
    udec_cts_partner i_udec_cts_partner (.i_clk(clk), .i_grant(grant), .o_cts_n(cts_n));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            conclude();
        end
    end
    function logic pin(input logic on);
        return on ^ pol;
    endfunction : pin
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task send(input logic [7:0] d);
        @(posedge clk) begin wr <= 1; data <= d; end
        @(posedge clk) wr <= 0;
    endtask : send
    task get(input logic [7:0] exp, input logic last);
        int k;
        k = 0;
        while (txd !== 1'b0 && k < 400) begin @(negedge clk); k++; end
        check({txd, de_pin}, {1'b0, pin(1)});
        repeat (2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin repeat (4) @(negedge clk); a[i] = txd; end
        check(a, exp);
        repeat (4) @(negedge clk);
        check({txd, de_pin}, {1'b1, pin(1)});
        if (last) begin
            repeat (2) @(negedge clk);
            check(de_pin, pin(1));
            repeat (2) @(negedge clk);
            check(de_pin, pin(0));
        end
    endtask : get
    task conclude();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        repeat (4) @(posedge clk);
        @(negedge clk) check({busy, rdy}, 2'b01);
        for (int t = 0; t < 6; t++) begin
            @(posedge clk) pol <= t[0];
            b = 8'($random(seed));
            c = 8'($random(seed));
            if (t < 2) begin
                send(t[0] ? 8'hFF : 8'h00);
                get(t[0] ? 8'hFF : 8'h00, 1);
            end else if (t < 4) begin
                send(c);
                send(b);
                get(c, 0);
                get(b, 1);
            end else begin
                @(posedge clk) flow <= 1;
                send(b);
                repeat (40) @(negedge clk);
                check(de_pin, pin(0));
                @(posedge clk) grant <= 1;
                w = 0;
                while (de_pin !== pin(1) && w < 20) begin @(negedge clk); w++; end
                check(8'(w >= 3 && w <= 7), 8'h01);
                get(b, 1);
                @(posedge clk) begin grant <= 0; flow <= 0; end
            end
            $display("test %0d done", t);
        end
        conclude();
    end
endmodule : udec_ctrl_tb
bind udec_ctrl udec_ctrl_checker i_udec_ctrl_checker (.*);
